// ### src/tc_cfg_pkg.sv
// types shared by the thermocouple config bank and its users
package tc_cfg_pkg;

   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [15:0] addr;
      logic [15:0] wdata;
   } acc_req_t;

   typedef struct packed {
      logic       modbus;
      logic [7:0] address;
      logic [5:0] baud_code;
      logic [1:0] framing;
   } line_cfg_t;

   typedef enum logic [2:0] {
      CMD_NONE,
      CMD_NAME,
      CMD_FIRMWARE,
      CMD_READ_ALL,
      CMD_READ_CHAN
   } ascii_kind_t;

endpackage

// ### src/tc_cfg_regs.svh
// register offsets, field positions, reset values and timing constants of the config bank
//
// Contract
// - baud code 03h..0Ah selects 1200..115200 baud
// - bits 7:6 select parity and stop bits
// - writable station address, host writes 1..247
// - wait programmed 0..30 ms before each reply
// - watchdog timeout 0..255 in 0.1 s units
// - readable timeout count, writing zero clears it
// - timeout status bit, writing one clears it
// - watchdog runs only while enable bit set
// - mode one: output commands also clear status
// - first-read flag reads one once after power-on
// - writing one reloads factory calibration
// - protocol bit: zero ascii, one modbus rtu
// - eight-bit channel enable mask
// - signed channel offset, host writes -128..127
// - junction offset is 8-bit two's complement
// - filter bit: zero 60 Hz, one 50 Hz
// - sample rate bit: one 8 Hz, zero 10 Hz
// - format bit: zero raw hex, one engineering
// - default switch forces ascii, address 0, 9600 n81
// - name and firmware queries answered with '!'
// - input read commands answered with '>'
// - junction compensation only while enable set
`ifndef TC_CFG_REGS_SVH
`define TC_CFG_REGS_SVH

`define TC_OFS_FAULT_ALIAS   16'h0081
`define TC_OFS_PROTOCOL      16'h0101
`define TC_OFS_FILTER        16'h0103
`define TC_OFS_WDT_MODE      16'h0104
`define TC_OFS_WDT_EN        16'h0105
`define TC_OFS_CJC_EN        16'h010c
`define TC_OFS_FORMAT        16'h010d
`define TC_OFS_WDT_FLAG      16'h010e
`define TC_OFS_CAL_RESTORE   16'h0110
`define TC_OFS_FIRST_READ    16'h0111
`define TC_OFS_SAMPLE_RATE   16'h0112
`define TC_OFS_OPEN_DET      16'h0114
`define TC_OFS_FAULT         16'h2791
`define TC_OFS_INPUT         16'h7531
`define TC_OFS_CJ_TEMP       16'h75b1
`define TC_OFS_INPUT_ALIAS   16'h9c41
`define TC_OFS_CJ_TEMP_ALIAS 16'h9cc1
`define TC_OFS_TYPE          16'h9d41
`define TC_OFS_TEMP_OFS      16'h9d61
`define TC_OFS_CJ_OFS        16'h9da1
`define TC_OFS_FW_LO         16'h9e21
`define TC_OFS_FW_HI         16'h9e22
`define TC_OFS_NAME_LO       16'h9e23
`define TC_OFS_NAME_HI       16'h9e24
`define TC_OFS_ADDR          16'h9e25
`define TC_OFS_LINE          16'h9e26
`define TC_OFS_DELAY         16'h9e28
`define TC_OFS_WDT_TIME      16'h9e29
`define TC_OFS_CH_MASK       16'h9e2a
`define TC_OFS_UNIT_CJ_OFS   16'h9e2b
`define TC_OFS_WDT_COUNT     16'h9e2c
`define TC_OFS_CJ_UPDATE     16'h9e2d

`define TC_LINE_BAUD_LSB     0
`define TC_LINE_BAUD_MSB     5
`define TC_LINE_FRAME_LSB    6
`define TC_LINE_FRAME_MSB    7

`define TC_BAUD_MIN          6'h03
`define TC_BAUD_MAX          6'h0a
`define TC_BAUD_9600         6'h06
`define TC_FRAME_N81         2'h0
`define TC_ADDR_MIN          16'h0001
`define TC_ADDR_MAX          16'h00f7
`define TC_DELAY_MAX         16'h001e
`define TC_WDT_TIME_MAX      16'h00ff
`define TC_CJ_UPDATE_MAX     16'h0002
`define TC_INIT_ADDR         8'h00

`define TC_RST_ADDR          8'h01
`define TC_RST_LINE          8'h06
`define TC_RST_CH_MASK       8'hff
`define TC_RST_DELAY         5'h00
`define TC_RST_WDT_TIME      8'h00

`define TC_LEAD_ANSWER       8'h21
`define TC_LEAD_DATA         8'h3e

`define TC_CLK_NS            10
`define TC_MS_NS             1000000
`define TC_TENTH_NS          100000000

`endif

// ### src/thermocouple_module_config_bank.sv
// configuration and status register bank of the eight-channel thermocouple module
`timescale 1ns/1ps
`include "tc_cfg_regs.svh"

module thermocouple_module_config_bank
   import tc_cfg_pkg::*;
#(
   parameter int          MS_CYCLES    = `TC_MS_NS / `TC_CLK_NS,
   parameter int          TENTH_CYCLES = `TC_TENTH_NS / `TC_CLK_NS,
   // identity words: arbitrary neutral values
   parameter logic [31:0] FW_VERSION   = 32'h0000_0001,
   parameter logic [31:0] UNIT_NAME    = 32'h0000_0001
) (
   // clock and reset
   input  wire logic             sys_clk,
   input  wire logic             rstn,
   // register access from the protocol engine
   input  wire acc_req_t         acc,
   output logic                  acc_done_q,
   output logic                  acc_err_q,
   output logic [15:0]           rd_data_q,
   // host traffic events
   input  wire logic             host_msg,
   input  wire logic             out_cmd,
   input  wire logic             reply_req,
   output logic                  reply_go_q,
   // ascii command decode
   input  wire ascii_kind_t      cmd_kind,
   input  wire logic [7:0]       cmd_addr,
   input  wire logic [7:0]       cmd_chan,
   output logic                  resp_valid_q,
   output logic [7:0]            resp_lead_q,
   // default-settings switch pin
   input  wire logic             init_sw,
   // measurement values
   input  wire logic [7:0][15:0] in_value,
   input  wire logic [15:0]      cj_temp,
   input  wire logic [7:0]       range_fault,
   // settings toward serial and analog logic, watchdog status
   output line_cfg_t             line_cfg_q,
   output logic [4:0]            reply_delay_q,
   output logic                  filter_50hz_q,
   output logic                  rate_8hz_q,
   output logic                  fmt_eng_q,
   output logic                  cold_junction_comp_q,
   output logic                  open_det_q,
   output logic [7:0]            ch_mask_q,
   output logic [7:0][15:0]      type_code_q,
   output logic [7:0][7:0]       temp_ofs_q,
   output logic [7:0][7:0]       cj_ofs_q,
   output logic [15:0]           unit_cj_ofs_q,
   output logic [1:0]            cj_update_q,
   output logic                  cal_restore_q,
   output logic                  wdt_flag_q,
   output logic [15:0]           wdt_count_q
);

   // channel window check: base .. base+7
   function automatic logic in_win(input logic [15:0] a, input logic [15:0] base);
      logic [15:0] d;
      d = a - base;
      return d < 16'h0008;
   endfunction

   function automatic logic [2:0] win_idx(input logic [15:0] a, input logic [15:0] base);
      logic [15:0] d;
      d = a - base;
      return d[2:0];
   endfunction

   logic             wr;
   logic             rd;
   logic [15:0]      a;
   logic [15:0]      wd;
   logic             modbus_q;
   logic [7:0]       addr_q;
   logic [7:0]       line_q;
   logic [7:0]       wdt_time_q;
   logic             wdt_mode_q;
   logic             wdt_en_q;
   logic             first_q;
   logic             sw_meta_q;
   logic             sw_q;
   logic [31:0]      pre_cnt_q;
   logic [7:0]       tenth_q;
   logic             wdt_run;
   logic             tenth_end;
   logic             wdt_fire;
   logic [15:0]      rd_d;
   logic             hit_d;
   logic             wr_ok_d;

   assign wr = acc.wr;
   assign rd = acc.rd;
   assign a  = acc.addr;
   assign wd = acc.wdata;

   // default switch pin crosses in through two flops
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         sw_meta_q <= 1'b0;
         sw_q      <= 1'b0;
      end else begin
         sw_meta_q <= init_sw;
         sw_q      <= sw_meta_q;
      end
   end

   // serial settings
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         modbus_q      <= 1'b0;
         addr_q        <= `TC_RST_ADDR;
         line_q        <= `TC_RST_LINE;
         reply_delay_q <= `TC_RST_DELAY;
      end else if (wr) begin
         if (a == `TC_OFS_PROTOCOL) begin
            modbus_q <= wd[0];
         end
         if (a == `TC_OFS_ADDR && wd >= `TC_ADDR_MIN && wd <= `TC_ADDR_MAX) begin
            addr_q <= wd[7:0];
         end
         if (a == `TC_OFS_LINE && wd[15:8] == 8'h00
             && wd[`TC_LINE_BAUD_MSB:`TC_LINE_BAUD_LSB] >= `TC_BAUD_MIN
             && wd[`TC_LINE_BAUD_MSB:`TC_LINE_BAUD_LSB] <= `TC_BAUD_MAX) begin
            line_q <= wd[7:0];
         end
         if (a == `TC_OFS_DELAY && wd <= `TC_DELAY_MAX) begin
            reply_delay_q <= wd[4:0];
         end
      end
   end

   // effective line settings; the switch overrides but never alters stored values
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         line_cfg_q <= '0;
      end else if (sw_q) begin
         // forced ascii, address 0, 9600 n81
         line_cfg_q.modbus    <= 1'b0;
         line_cfg_q.address   <= `TC_INIT_ADDR;
         line_cfg_q.baud_code <= `TC_BAUD_9600;
         line_cfg_q.framing   <= `TC_FRAME_N81;
      end else begin
         line_cfg_q.modbus    <= modbus_q;
         line_cfg_q.address   <= addr_q;
         line_cfg_q.baud_code <= line_q[`TC_LINE_BAUD_MSB:`TC_LINE_BAUD_LSB];
         line_cfg_q.framing   <= line_q[`TC_LINE_FRAME_MSB:`TC_LINE_FRAME_LSB];
      end
   end

   // measurement and analog options
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         filter_50hz_q        <= 1'b0;
         rate_8hz_q           <= 1'b0;
         fmt_eng_q            <= 1'b0;
         cold_junction_comp_q <= 1'b0;
         open_det_q           <= 1'b0;
         ch_mask_q            <= `TC_RST_CH_MASK;
         unit_cj_ofs_q        <= 16'h0000;
         cj_update_q          <= 2'h0;
      end else if (wr) begin
         if (a == `TC_OFS_FILTER) begin
            filter_50hz_q <= wd[0];
         end
         if (a == `TC_OFS_SAMPLE_RATE) begin
            rate_8hz_q <= wd[0];
         end
         if (a == `TC_OFS_FORMAT) begin
            fmt_eng_q <= wd[0];
         end
         if (a == `TC_OFS_CJC_EN) begin
            cold_junction_comp_q <= wd[0];
         end
         if (a == `TC_OFS_OPEN_DET) begin
            open_det_q <= wd[0];
         end
         if (a == `TC_OFS_CH_MASK && wd[15:8] == 8'h00) begin
            ch_mask_q <= wd[7:0];
         end
         if (a == `TC_OFS_UNIT_CJ_OFS) begin
            unit_cj_ofs_q <= wd;
         end
         if (a == `TC_OFS_CJ_UPDATE && wd <= `TC_CJ_UPDATE_MAX) begin
            cj_update_q <= wd[1:0];
         end
      end
   end

   // per-channel settings
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         type_code_q <= '0;
         temp_ofs_q  <= '0;
         cj_ofs_q    <= '0;
      end else if (wr) begin
         if (in_win(a, `TC_OFS_TYPE)) begin
            type_code_q[win_idx(a, `TC_OFS_TYPE)] <= wd;
         end
         if (in_win(a, `TC_OFS_TEMP_OFS) && (wd[15:7] == 9'h000 || wd[15:7] == 9'h1ff)) begin
            temp_ofs_q[win_idx(a, `TC_OFS_TEMP_OFS)] <= wd[7:0];
         end
         // raw byte kept as two's complement
         if (in_win(a, `TC_OFS_CJ_OFS) && wd[15:8] == 8'h00) begin
            cj_ofs_q[win_idx(a, `TC_OFS_CJ_OFS)] <= wd[7:0];
         end
      end
   end

   // watchdog controls
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         wdt_time_q <= `TC_RST_WDT_TIME;
         wdt_mode_q <= 1'b0;
         wdt_en_q   <= 1'b0;
      end else if (wr) begin
         if (a == `TC_OFS_WDT_TIME && wd <= `TC_WDT_TIME_MAX) begin
            wdt_time_q <= wd[7:0];
         end
         if (a == `TC_OFS_WDT_MODE) begin
            wdt_mode_q <= wd[0];
         end
         if (a == `TC_OFS_WDT_EN) begin
            wdt_en_q <= wd[0];
         end
      end
   end

   // a zero timeout would wrap and fire only after 256 tenths, so it holds the watchdog idle
   // runs only while enabled
   assign wdt_run   = wdt_en_q && wdt_time_q != 8'h00 && !host_msg;
   assign tenth_end = pre_cnt_q == 32'(TENTH_CYCLES - 1);
   assign wdt_fire  = wdt_run && tenth_end && (tenth_q + 8'h01) == wdt_time_q;

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         pre_cnt_q <= 32'h0000_0000;
         tenth_q   <= 8'h00;
      end else if (!wdt_run || wdt_fire) begin
         pre_cnt_q <= 32'h0000_0000;
         tenth_q   <= 8'h00;
      end else if (tenth_end) begin
         pre_cnt_q <= 32'h0000_0000;
         tenth_q   <= tenth_q + 8'h01;
      end else begin
         pre_cnt_q <= pre_cnt_q + 32'h0000_0001;
      end
   end

   // a timeout in the clearing cycle wins over the clear
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         wdt_flag_q <= 1'b0;
      end else if (wdt_fire) begin
         wdt_flag_q <= 1'b1;
      end else if (wr && a == `TC_OFS_WDT_FLAG && wd[0]) begin
         wdt_flag_q <= 1'b0;
      end else if (wdt_mode_q && out_cmd) begin
         wdt_flag_q <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         wdt_count_q <= 16'h0000;
      end else if (wr && a == `TC_OFS_WDT_COUNT && wd == 16'h0000) begin
         // zero write clears, a coincident timeout still counts
         wdt_count_q <= {15'h0000, wdt_fire};
      end else if (wdt_fire && wdt_count_q != 16'hffff) begin
         wdt_count_q <= wdt_count_q + 16'h0001;
      end
   end

   // calibration reload strobe
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         cal_restore_q <= 1'b0;
      end else begin
         cal_restore_q <= wr && a == `TC_OFS_CAL_RESTORE && wd[0];
      end
   end

   // power-on first read
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         first_q <= 1'b1;
      end else if (rd && a == `TC_OFS_FIRST_READ) begin
         first_q <= 1'b0;
      end
   end

   // read decode
   always_comb begin
      rd_d  = 16'h0000;
      hit_d = 1'b1;
      if (in_win(a, `TC_OFS_FAULT_ALIAS)) begin
         rd_d = {15'h0000, range_fault[win_idx(a, `TC_OFS_FAULT_ALIAS)]};
      end else if (in_win(a, `TC_OFS_FAULT)) begin
         rd_d = {15'h0000, range_fault[win_idx(a, `TC_OFS_FAULT)]};
      end else if (in_win(a, `TC_OFS_INPUT)) begin
         rd_d = in_value[win_idx(a, `TC_OFS_INPUT)];
      end else if (in_win(a, `TC_OFS_INPUT_ALIAS)) begin
         rd_d = in_value[win_idx(a, `TC_OFS_INPUT_ALIAS)];
      end else if (in_win(a, `TC_OFS_TYPE)) begin
         rd_d = type_code_q[win_idx(a, `TC_OFS_TYPE)];
      end else if (in_win(a, `TC_OFS_TEMP_OFS)) begin
         rd_d = {{8{temp_ofs_q[win_idx(a, `TC_OFS_TEMP_OFS)][7]}},
                 temp_ofs_q[win_idx(a, `TC_OFS_TEMP_OFS)]};
      end else if (in_win(a, `TC_OFS_CJ_OFS)) begin
         rd_d = {8'h00, cj_ofs_q[win_idx(a, `TC_OFS_CJ_OFS)]};
      end else begin
         case (a)
            `TC_OFS_PROTOCOL:      rd_d = {15'h0000, modbus_q};
            `TC_OFS_FILTER:        rd_d = {15'h0000, filter_50hz_q};
            `TC_OFS_WDT_MODE:      rd_d = {15'h0000, wdt_mode_q};
            `TC_OFS_WDT_EN:        rd_d = {15'h0000, wdt_en_q};
            `TC_OFS_CJC_EN:        rd_d = {15'h0000, cold_junction_comp_q};
            `TC_OFS_FORMAT:        rd_d = {15'h0000, fmt_eng_q};
            `TC_OFS_WDT_FLAG:      rd_d = {15'h0000, wdt_flag_q};
            `TC_OFS_FIRST_READ:    rd_d = {15'h0000, first_q};
            `TC_OFS_SAMPLE_RATE:   rd_d = {15'h0000, rate_8hz_q};
            `TC_OFS_OPEN_DET:      rd_d = {15'h0000, open_det_q};
            `TC_OFS_CJ_TEMP:       rd_d = cj_temp;
            `TC_OFS_CJ_TEMP_ALIAS: rd_d = cj_temp;
            `TC_OFS_FW_LO:         rd_d = FW_VERSION[15:0];
            `TC_OFS_FW_HI:         rd_d = FW_VERSION[31:16];
            `TC_OFS_NAME_LO:       rd_d = UNIT_NAME[15:0];
            `TC_OFS_NAME_HI:       rd_d = UNIT_NAME[31:16];
            `TC_OFS_ADDR:          rd_d = {8'h00, addr_q};
            `TC_OFS_LINE:          rd_d = {8'h00, line_q};
            `TC_OFS_DELAY:         rd_d = {11'h000, reply_delay_q};
            `TC_OFS_WDT_TIME:      rd_d = {8'h00, wdt_time_q};
            `TC_OFS_CH_MASK:       rd_d = {8'h00, ch_mask_q};
            `TC_OFS_UNIT_CJ_OFS:   rd_d = unit_cj_ofs_q;
            `TC_OFS_WDT_COUNT:     rd_d = wdt_count_q;
            `TC_OFS_CJ_UPDATE:     rd_d = {14'h0000, cj_update_q};
            `TC_OFS_CAL_RESTORE:   hit_d = 1'b0;
            default:               hit_d = 1'b0;
         endcase
      end
   end

   // writable addresses; read-only ones refuse a write
   always_comb begin
      wr_ok_d = in_win(a, `TC_OFS_TYPE) || in_win(a, `TC_OFS_TEMP_OFS)
                || in_win(a, `TC_OFS_CJ_OFS);
      case (a)
         `TC_OFS_PROTOCOL, `TC_OFS_FILTER, `TC_OFS_WDT_MODE, `TC_OFS_WDT_EN,
         `TC_OFS_CJC_EN, `TC_OFS_FORMAT, `TC_OFS_WDT_FLAG, `TC_OFS_CAL_RESTORE,
         `TC_OFS_SAMPLE_RATE, `TC_OFS_OPEN_DET, `TC_OFS_ADDR, `TC_OFS_LINE,
         `TC_OFS_DELAY, `TC_OFS_WDT_TIME, `TC_OFS_CH_MASK, `TC_OFS_UNIT_CJ_OFS,
         `TC_OFS_WDT_COUNT, `TC_OFS_CJ_UPDATE: wr_ok_d = 1'b1;
         default: ;
      endcase
   end

   // access answer one cycle after the request
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         acc_done_q <= 1'b0;
         acc_err_q  <= 1'b0;
         rd_data_q  <= 16'h0000;
      end else begin
         acc_done_q <= rd || wr;
         acc_err_q  <= (rd && !hit_d) || (wr && !wr_ok_d);
         if (rd) begin
            rd_data_q <= hit_d ? rd_d : 16'h0000;
         end
      end
   end

   // reply delay timer; a new request while waiting is ignored and the running wait continues
   typedef enum logic {DLY_IDLE, DLY_WAIT} dly_state_t;
   dly_state_t  dly_q;
   logic [31:0] ms_cnt_q;
   logic [4:0]  ms_left_q;

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         dly_q      <= DLY_IDLE;
         ms_cnt_q   <= 32'h0000_0000;
         ms_left_q  <= 5'h00;
         reply_go_q <= 1'b0;
      end else begin
         reply_go_q <= 1'b0;
         case (dly_q)
            DLY_IDLE: begin
               if (reply_req && reply_delay_q == 5'h00) begin
                  reply_go_q <= 1'b1;
               end else if (reply_req) begin
                  dly_q     <= DLY_WAIT;
                  ms_cnt_q  <= 32'h0000_0000;
                  ms_left_q <= reply_delay_q;
               end
            end
            DLY_WAIT: begin
               if (ms_cnt_q != 32'(MS_CYCLES - 1)) begin
                  ms_cnt_q <= ms_cnt_q + 32'h0000_0001;
               end else if (ms_left_q == 5'h01) begin
                  reply_go_q <= 1'b1;
                  dly_q      <= DLY_IDLE;
               end else begin
                  ms_cnt_q  <= 32'h0000_0000;
                  ms_left_q <= ms_left_q - 5'h01;
               end
            end
            default: dly_q <= DLY_IDLE;
         endcase
      end
   end

   // ascii answer lead character
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         resp_valid_q <= 1'b0;
         resp_lead_q  <= 8'h00;
      end else begin
         resp_valid_q <= 1'b0;
         if (!line_cfg_q.modbus && cmd_addr == line_cfg_q.address) begin
            case (cmd_kind)
               CMD_NAME, CMD_FIRMWARE: begin
                  resp_valid_q <= 1'b1;
                  resp_lead_q  <= `TC_LEAD_ANSWER;
               end
               CMD_READ_ALL: begin
                  resp_valid_q <= 1'b1;
                  resp_lead_q  <= `TC_LEAD_DATA;
               end
               CMD_READ_CHAN: begin
                  resp_valid_q <= cmd_chan < 8'h08;
                  resp_lead_q  <= `TC_LEAD_DATA;
               end
               default: ;
            endcase
         end
      end
   end

endmodule

// ### verif/tc_cfg_sva.sv
// port assertions of the thermocouple config bank
`timescale 1ns/1ps
`include "tc_cfg_regs.svh"
module tc_cfg_sva
   import tc_cfg_pkg::*;
(
   // clock and reset
   input wire logic        sys_clk,
   input wire logic        rstn,
   // requests and events
   input wire acc_req_t    acc,
   input wire logic        out_cmd,
   input wire ascii_kind_t cmd_kind,
   input wire logic [7:0]  cmd_chan,
   // outputs
   input wire logic        acc_done_q,
   input wire logic        resp_valid_q,
   input wire logic [7:0]  resp_lead_q,
   input wire line_cfg_t   line_cfg_q,
   input wire logic [4:0]  reply_delay_q,
   input wire logic        cal_restore_q,
   input wire logic        wdt_flag_q,
   input wire logic [15:0] wdt_count_q
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   AST_DONE: assert property ((acc.rd || acc.wr) |=> acc_done_q)
      else $error("access not answered");
   AST_BAUD: assert property (acc_done_q |-> line_cfg_q.baud_code inside {[6'h03:6'h0a]})
      else $error("baud code out of range");
   AST_DELAY: assert property (reply_delay_q <= 5'd30)
      else $error("reply delay above 30");
   AST_HOLD: assert property (wdt_flag_q && !acc.wr && !out_cmd |=> wdt_flag_q)
      else $error("timeout status lost");
   AST_COUNT: assert property ($rose(wdt_flag_q) && $past(wdt_count_q) != 16'hffff
      && !$past(acc.wr) |-> wdt_count_q == $past(wdt_count_q) + 16'h0001)
      else $error("timeout count not bumped");
   AST_BANG: assert property (resp_valid_q && $past(cmd_kind)
      inside {CMD_NAME, CMD_FIRMWARE} |-> resp_lead_q == `TC_LEAD_ANSWER)
      else $error("query answer lead wrong");
   AST_CHAN: assert property (cmd_kind == CMD_READ_CHAN && cmd_chan >= 8'h08 |=> !resp_valid_q)
      else $error("answer to absent channel");
   AST_CAL: assert property (cal_restore_q |-> $past(acc.wr)
      && $past(acc.addr) == `TC_OFS_CAL_RESTORE)
      else $error("calibration reload without write");
   cover property (resp_valid_q);
   cover property ($rose(wdt_flag_q));
   cover property (cal_restore_q);
endmodule

// ### verif/tc_host_model.sv
// serial host stand-in issuing register requests
`timescale 1ns/1ps
module tc_host_model
   import tc_cfg_pkg::*;
(
   // clock
   input  wire logic        sys_clk,
   // register access
   output acc_req_t         acc,
   input  wire logic        acc_done_q,
   input  wire logic        acc_err_q,
   input  wire logic [15:0] rd_data_q
);
   initial acc = '0;
   // one pulse per request; released fields show inverted values
   task automatic xfer(input logic w, input logic [15:0] a, d,
                       output logic [15:0] r, output logic e, dn);
      @(negedge sys_clk);
      acc = '{rd: !w, wr: w, addr: a, wdata: d};
      @(negedge sys_clk);
      r  = rd_data_q;
      e  = acc_err_q;
      dn = acc_done_q;
      acc = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
   endtask
endmodule

// ### verif/thermocouple_module_config_bank_tb_top.sv
// self-checking bench of the thermocouple config bank
`timescale 1ns/1ps
`include "tc_cfg_regs.svh"
module thermocouple_module_config_bank_tb_top
   import tc_cfg_pkg::*;
;
   localparam int MS = 4;
   logic        sys_clk = 1'b0, rstn = 1'b0, out_cmd = 1'b0, reply_req = 1'b0, init_sw = 1'b0;
   logic        host_msg = 1'b0;
   logic        cal, err, done, acc_done_q, acc_err_q, reply_go_q, resp_valid_q, wdt_flag_q;
   logic        filter_50hz_q, rate_8hz_q, fmt_eng_q, cold_junction_comp_q, cal_restore_q;
   logic [7:0]  cmd_addr = 8'h05, cmd_chan = 8'h00, resp_lead_q;
   logic [4:0]  reply_delay_q;
   logic [15:0] rd_data_q, wdt_count_q, rv;
   logic [31:0] s = 32'h000056d8, x;
   ascii_kind_t cmd_kind = CMD_NONE;
   acc_req_t    acc;
   line_cfg_t   line_cfg_q;
   int          failures = 0, n_checks = 0, n;
   int          m [int] = '{`TC_OFS_ADDR: `TC_RST_ADDR, `TC_OFS_LINE: `TC_RST_LINE};
   logic [15:0] bits [5] = '{`TC_OFS_PROTOCOL, `TC_OFS_FILTER, `TC_OFS_SAMPLE_RATE,
                             `TC_OFS_FORMAT, `TC_OFS_CJC_EN};
   tc_host_model i_host (.sys_clk, .acc, .acc_done_q, .acc_err_q, .rd_data_q);
   thermocouple_module_config_bank #(.MS_CYCLES(MS), .TENTH_CYCLES(4)) i_dut (
      .sys_clk, .rstn, .acc, .acc_done_q, .acc_err_q, .rd_data_q, .host_msg, .out_cmd,
      .reply_req, .reply_go_q, .cmd_kind, .cmd_addr, .cmd_chan, .resp_valid_q, .resp_lead_q,
      .init_sw, .in_value('0), .cj_temp(16'h0000), .range_fault(8'h00), .line_cfg_q,
      .reply_delay_q, .filter_50hz_q, .rate_8hz_q, .fmt_eng_q, .cold_junction_comp_q,
      .open_det_q(), .ch_mask_q(), .type_code_q(), .temp_ofs_q(), .cj_ofs_q(),
      .unit_cj_ofs_q(), .cj_update_q(), .cal_restore_q, .wdt_flag_q, .wdt_count_q);
   initial forever #5 sys_clk = ~sys_clk;
   function automatic logic [31:0] xs();
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      s = s ^ (s << 5);
      return s;
   endfunction
   function automatic bit ok(logic [15:0] a, d);
      case (a)
         `TC_OFS_ADDR: return d >= `TC_ADDR_MIN && d <= `TC_ADDR_MAX;
         `TC_OFS_LINE: return d[15:8] == 0 && d[5:0] >= `TC_BAUD_MIN && d[5:0] <= `TC_BAUD_MAX;
         default:      return 1'b1;
      endcase
   endfunction
   task chk(string w, logic [31:0] seen, exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("FAIL %s expected %h seen %h", w, exp, seen);
      end
   endtask
   task end_of_test;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task wr(input logic [15:0] a, d);
      i_host.xfer(1'b1, a, d, rv, err, done);
      cal = cal_restore_q;
      chk("wdone", {done, err}, 2);
      if (ok(a, d)) m[a] = d;
      @(negedge sys_clk);
   endtask
   task rd(input logic [15:0] a);
      i_host.xfer(1'b0, a, 16'h0000, rv, err, done);
      if (m.exists(a)) chk("rdata", rv, m[a]);
   endtask
   task hold(input bit f, output int k);
      k = 0;
      do begin
         @(negedge sys_clk);
         {reply_req, host_msg} = 2'b00;
         k++;
      end while ((f ? wdt_flag_q : reply_go_q) !== 1'b1 && k < 60);
      if (k >= 60) begin
         failures++;
         end_of_test();
      end
   endtask
   initial begin
      repeat (2) @(negedge sys_clk);
      rstn = 1'b1;
      rd(`TC_OFS_FIRST_READ);
      chk("first", rv, 1);
      rd(`TC_OFS_FIRST_READ);
      chk("later", rv, 0);
      wr(`TC_OFS_ADDR, 16'h0005);
      wr(`TC_OFS_ADDR, 16'h0000);
      wr(`TC_OFS_ADDR, 16'h00f8);
      chk("addr", line_cfg_q.address, 5);
      for (int b = 2; b <= 11; b++) begin
         wr(`TC_OFS_LINE, {8'h00, 2'(b), 6'(b)});
         chk("line", {line_cfg_q.framing, line_cfg_q.baud_code}, m[`TC_OFS_LINE]);
      end
      for (int i = 0; i < 8; i++) begin
         x = xs();
         wr(`TC_OFS_CH_MASK, {8'h00, x[7:0]});
         rd(`TC_OFS_CH_MASK);
         wr(`TC_OFS_TEMP_OFS + 16'(i), {{8{x[15]}}, x[15:8]});
         rd(`TC_OFS_TEMP_OFS + 16'(i));
         wr(`TC_OFS_CJ_OFS + 16'(i), {8'h00, x[23:16]});
         rd(`TC_OFS_CJ_OFS + 16'(i));
      end
      for (int v = 1; v >= 0; v--) begin
         foreach (bits[j]) wr(bits[j], 16'(v));
         chk("bits", {line_cfg_q.modbus, filter_50hz_q, rate_8hz_q, fmt_eng_q,
             cold_junction_comp_q}, {5{v[0]}});
      end
      wr(`TC_OFS_DELAY, 16'd31);
      wr(`TC_OFS_DELAY, 16'd1);
      reply_req = 1'b1;
      hold(1'b0, n);
      chk("gap", n, MS + 1);
      host_msg = 1'b1;
      wr(`TC_OFS_WDT_TIME, 16'd5);
      wr(`TC_OFS_WDT_EN, 16'd1);
      hold(1'b1, n);
      chk("wdt", n, 21);
      rd(`TC_OFS_WDT_COUNT);
      chk("count", rv, 1);
      wr(`TC_OFS_WDT_FLAG, 16'd1);
      chk("w1c", wdt_flag_q, 0);
      wr(`TC_OFS_WDT_MODE, 16'd1);
      hold(1'b1, n);
      out_cmd = 1'b1;
      @(negedge sys_clk);
      out_cmd = 1'b0;
      @(negedge sys_clk);
      chk("outclr", wdt_flag_q, 0);
      wr(`TC_OFS_WDT_COUNT, 16'd0);
      rd(`TC_OFS_WDT_COUNT);
      chk("zero", rv, 0);
      wr(`TC_OFS_WDT_EN, 16'd0);
      wr(`TC_OFS_WDT_FLAG, 16'd1);
      repeat (40) @(negedge sys_clk);
      chk("off", wdt_flag_q, 0);
      wr(`TC_OFS_CAL_RESTORE, 16'd1);
      chk("cal", cal, 1);
      for (int j = 0; j < 5; j++) begin
         cmd_kind = ascii_kind_t'(j < 4 ? j + 1 : 4);
         cmd_chan = 8'(j + 4);
         @(negedge sys_clk);
         chk("resp", {resp_valid_q, resp_lead_q}, {j != 4,
             j < 2 ? `TC_LEAD_ANSWER : `TC_LEAD_DATA});
         cmd_kind = CMD_NONE;
         @(negedge sys_clk);
      end
      init_sw = 1'b1;
      repeat (5) @(negedge sys_clk);
      chk("init", line_cfg_q, {1'b0, `TC_INIT_ADDR, `TC_BAUD_9600, `TC_FRAME_N81});
      end_of_test();
   end
endmodule
bind thermocouple_module_config_bank tc_cfg_sva i_sva (.sys_clk, .rstn, .acc, .out_cmd,
   .cmd_kind, .cmd_chan, .acc_done_q, .resp_valid_q, .resp_lead_q, .line_cfg_q,
   .reply_delay_q, .cal_restore_q, .wdt_flag_q, .wdt_count_q);
